// ==== shared/ghj_pkg.sv ====
/*
 * Shared definitions for the port G/H/J pin controller: register byte
 * addresses, reset values, selector codes, pin positions, bus carrier.
 * Assumes a 32-bit system bus with byte addresses, one word per register.
 */
package ghj_pkg;

	// ****************************************************************
	// register byte addresses
	// ****************************************************************
	localparam logic [31:0] G_FUNC_ADDR = 32'h5600_0060;
	localparam logic [31:0] G_DATA_ADDR = 32'h5600_0064;
	localparam logic [31:0] G_PULL_ADDR = 32'h5600_0068;
	localparam logic [31:0] H_FUNC_ADDR = 32'h5600_0070;
	localparam logic [31:0] H_DATA_ADDR = 32'h5600_0074;
	localparam logic [31:0] H_PULL_ADDR = 32'h5600_0078;
	localparam logic [31:0] H_RSVD_ADDR = 32'h5600_007C;
	localparam logic [31:0] J_FUNC_ADDR = 32'h5600_00D0;
	localparam logic [31:0] J_DATA_ADDR = 32'h5600_00D4;
	localparam logic [31:0] J_PULL_ADDR = 32'h5600_00D8;
	localparam logic [31:0] J_RSVD_ADDR = 32'h5600_00DC;

	// ****************************************************************
	// reset values and fixed fields
	// ****************************************************************
	localparam logic [31:0] FUNC_RST = 32'h0000_0000;
	localparam logic [31:0] DATA_RST = 32'h0000_0000;
	localparam logic [31:0] H_PULL_RST = 32'h2AAA_AAAA;
	localparam logic [31:0] J_PULL_RST = 32'h0AAA_AAAA;
	localparam logic [15:0] G_PULL_RST = 16'hAAAA;
	localparam int G_PULL_LSB = 16;
	// pins 7..0 of port G take pulls elsewhere; selector 01 keeps them off
	localparam logic [15:0] G_LOW_PULL_OFF = 16'h5555;

	// ****************************************************************
	// pin counts, selector codes, pin positions
	// ****************************************************************
	localparam int G_PINS = 16;
	localparam int H_PINS = 15;
	localparam int J_PINS = 16;
	typedef enum logic [1:0] {FN_INPUT, FN_OUTPUT, FN_PERIPH, FN_ALT} ghj_fn_e;
	localparam logic [1:0] PULL_UP = 2'h0;
	localparam logic [1:0] PULL_DOWN = 2'h2;
	localparam int UART_CHANNELS = 4;
	localparam int H_CTS0_PIN = 8;
	localparam int H_RTS0_PIN = 9;
	localparam int H_CTS1_PIN = 10;
	localparam int H_RTS1_PIN = 11;
	localparam int H_EXTCLK_PIN = 12;
	localparam int H_CLK_OUT0_PIN = 13;
	localparam int H_CLK_OUT1_PIN = 14;
	localparam int H_RTS2_PIN = 6;
	localparam int H_CTS2_PIN = 7;
	localparam int CAM_BITS = 8;
	localparam int J_PCLK_PIN = 8;
	localparam int J_VSYNC_PIN = 9;
	localparam int J_HREF_PIN = 10;
	localparam int J_CAMCLK_PIN = 11;
	localparam int J_CAMRST_PIN = 12;
	localparam int J_LED_PIN = 13;
	localparam int J_CD_PIN = 14;
	localparam int J_WP_PIN = 15;
	// which pins drive in peripheral (10) and second-function (11) modes
	localparam logic [14:0] H_FN_OUT_MASK = 15'h6A55;
	localparam logic [14:0] H_ALT_OK_MASK = 15'h00C0;
	localparam logic [14:0] H_ALT_OUT_MASK = 15'h0040;
	localparam logic [15:0] J_FN_OUT_MASK = 16'h3800;

	// system bus request carrier
	typedef struct packed {
		logic [31:0] addr;
		logic [31:0] wdata;
		logic wr;
		logic rd;
	} ghj_bus_s;

endpackage

// ==== verilog/ghj_port_cell.sv ====
/*
 * One port's pin cells: function select, output drive and enable, pull
 * decode, and the data-register read value, one generate lane per pin.
 * Assumes selector/data/pull words come from flops of the register file.
 */
`timescale 1ns/1ns
module ghj_port_cell
	import ghj_pkg::*;
#(
	parameter int PINS = 16,
	parameter logic [PINS-1:0] FN_OUT_MASK = '0,
	parameter logic [PINS-1:0] ALT_OK_MASK = '0,
	parameter logic [PINS-1:0] ALT_OUT_MASK = '0
) (
	input wire logic ref_clk,
	input wire logic rst_n,
	input wire logic [2*PINS-1:0] func,
	input wire logic [PINS-1:0] data,
	input wire logic [2*PINS-1:0] pull,
	input wire logic [PINS-1:0] pin_i,
	input wire logic [PINS-1:0] fn_o,
	input wire logic [PINS-1:0] alt_o,
	output logic [PINS-1:0] pin_o,
	output logic [PINS-1:0] pin_oe,
	output logic [PINS-1:0] pull_up_en,
	output logic [PINS-1:0] pull_down_en,
	output logic [PINS-1:0] read_val
);

	// ****************************************************************
	// per-pin lanes
	// ****************************************************************
	for (genvar i = 0; i < PINS; i++) begin : g_pin
		logic [1:0] sel;
		logic o_q;
		logic oe_q;
		logic pu_q;
		logic pd_q;
		assign sel = func[2*i +: 2];

		// drive and enable follow the selector one edge after it changes
		always_ff @(posedge ref_clk) begin
			if (!rst_n) begin
				o_q <= 1'b0;
				oe_q <= 1'b0;
			end else begin
				case (ghj_fn_e'(sel))
					FN_INPUT: begin
						o_q <= 1'b0;
						oe_q <= 1'b0;
					end
					FN_OUTPUT: begin
						o_q <= data[i];
						oe_q <= 1'b1;
					end
					FN_PERIPH: begin
						o_q <= fn_o[i];
						oe_q <= FN_OUT_MASK[i];
					end
					default: begin // code 11 drives alt_o only where both alt masks are set, else floats
						o_q <= alt_o[i];
						oe_q <= ALT_OK_MASK[i] & ALT_OUT_MASK[i];
					end
				endcase
			end
		end

		// pull decode: only 00 and 10 switch a resistor on
		always_ff @(posedge ref_clk) begin
			if (!rst_n) begin
				pu_q <= 1'b0;
				pd_q <= 1'b0;
			end else begin
				pu_q <= (pull[2*i +: 2] == PULL_UP);
				pd_q <= (pull[2*i +: 2] == PULL_DOWN);
			end
		end

		assign pin_o[i] = o_q;
		assign pin_oe[i] = oe_q;
		assign pull_up_en[i] = pu_q;
		assign pull_down_en[i] = pd_q;
		// functional pins return the raw pin, which software must ignore
		assign read_val[i] = (sel == FN_OUTPUT) ? data[i] : pin_i[i];
	end

endmodule // ghj_port_cell

// ==== verilog/ghj_gpio_ports.sv ====
/*
 * Register file and pin routing for general-purpose ports G (selector, data and
 * upper pulls), H and J, with UART, camera and card-slot functions.
 * Assumes a single-cycle register port, pins sampled on ref_clk, and pad
 * cells that resolve pin_o/pin_oe and the pull enables outside.
 */
// Implementation choice: the strobed register port.
`timescale 1ns/1ns

// Function
// - input-mode pins read back the sampled pin level in the data register.
// - output-mode pins are driven with their data register bit.
// - data bits of peripheral-function pins read an undefined value.
// - pull code 00 pulls up, 10 pulls down, 01 and 11 disable both.
// - port G pull register holds pins 15..8 in bits 31..16 only.
// - two selector bits per pin: 00 input, 01 output, 10 peripheral, 11 second.
// - port H code 11 gives channel 2 flow control on pins 7 and 6.
// - port H code 10 routes UART data, flow control, serial clock, clock outputs.
// - port J code 10 routes camera signals and card-slot status pins.
// - port H and J function selectors reset to zero, all inputs.
// - port H pull register resets to 0x2AAAAAAA, pull-down everywhere.
// - port J pull register resets to 0xAAAAAAA.
// - port H and J data registers have no defined reset value.
// - port H registers decode at 0x56000070, 0x56000074, 0x56000078.
// - port J registers decode at 0x560000d0, 0x560000d4, 0x560000d8.
// - port G selector resets to zero, upper pull half to pull-down.
module ghj_gpio_ports
	import ghj_pkg::*;
(
	input wire logic ref_clk,
	input wire logic rst_n,
	input wire ghj_bus_s bus,
	output logic [31:0] rdata,
	input wire logic [G_PINS-1:0] g_pin_i,
	output logic [G_PINS-1:0] g_pin_o,
	output logic [G_PINS-1:0] g_pin_oe,
	output logic [G_PINS-1:0] g_pull_up_en,
	output logic [G_PINS-1:0] g_pull_down_en,
	input wire logic [H_PINS-1:0] h_pin_i,
	output logic [H_PINS-1:0] h_pin_o,
	output logic [H_PINS-1:0] h_pin_oe,
	output logic [H_PINS-1:0] h_pull_up_en,
	output logic [H_PINS-1:0] h_pull_down_en,
	input wire logic [J_PINS-1:0] j_pin_i,
	output logic [J_PINS-1:0] j_pin_o,
	output logic [J_PINS-1:0] j_pin_oe,
	output logic [J_PINS-1:0] j_pull_up_en,
	output logic [J_PINS-1:0] j_pull_down_en,
	input wire logic [UART_CHANNELS-1:0] uart_txd,
	output logic [UART_CHANNELS-1:0] uart_rxd,
	input wire logic [2:0] request_to_send_n,
	output logic [2:0] clear_to_send_n,
	output logic external_serial_clock,
	input wire logic clock_output_zero,
	input wire logic clock_output_one,
	output logic [CAM_BITS-1:0] camera_pixel_bus,
	output logic camera_pixel_clock,
	output logic camera_vertical_sync,
	output logic camera_line_reference,
	input wire logic camera_master_clock,
	input wire logic camera_reset_line,
	input wire logic card0_activity_led,
	output logic card0_detect_n,
	output logic card0_write_protect_n
);

	// ****************************************************************
	// register storage
	// ****************************************************************
	logic [31:0] g_func;
	logic [G_PINS-1:0] g_data;
	logic [15:0] g_pull_hi;
	logic [2*H_PINS-1:0] h_func;
	logic [H_PINS-1:0] h_data;
	logic [2*H_PINS-1:0] h_pull;
	logic [31:0] j_func;
	logic [J_PINS-1:0] j_data;
	logic [31:0] j_pull;
	logic [G_PINS-1:0] g_read;
	logic [H_PINS-1:0] h_read;
	logic [J_PINS-1:0] j_read;
	logic [31:0] next_rdata;
	logic [H_PINS-1:0] h_fn_o;
	logic [H_PINS-1:0] h_alt_o;
	logic [J_PINS-1:0] j_fn_o;

	// port G words; lower pull half is not stored at all
	always_ff @(posedge ref_clk) begin
		if (!rst_n) begin
			g_func <= FUNC_RST;
			g_data <= DATA_RST[G_PINS-1:0];
			g_pull_hi <= G_PULL_RST;
		end else if (bus.wr) begin
			if (bus.addr == G_FUNC_ADDR)
				g_func <= bus.wdata;
			if (bus.addr == G_DATA_ADDR)
				g_data <= bus.wdata[G_PINS-1:0];
			if (bus.addr == G_PULL_ADDR)
				g_pull_hi <= bus.wdata[31:G_PULL_LSB];
		end
	end

	// port H words; bits above pin 14 are not implemented
	always_ff @(posedge ref_clk) begin
		if (!rst_n) begin
			h_func <= FUNC_RST[2*H_PINS-1:0];
			h_data <= DATA_RST[H_PINS-1:0]; // tidy value only
			h_pull <= H_PULL_RST[2*H_PINS-1:0];
		end else if (bus.wr) begin
			if (bus.addr == H_FUNC_ADDR)
				h_func <= bus.wdata[2*H_PINS-1:0];
			if (bus.addr == H_DATA_ADDR)
				h_data <= bus.wdata[H_PINS-1:0];
			if (bus.addr == H_PULL_ADDR)
				h_pull <= bus.wdata[2*H_PINS-1:0];
		end
	end

	// port J words
	always_ff @(posedge ref_clk) begin
		if (!rst_n) begin
			j_func <= FUNC_RST;
			j_data <= DATA_RST[J_PINS-1:0]; // tidy value only
			j_pull <= J_PULL_RST;
		end else if (bus.wr) begin
			if (bus.addr == J_FUNC_ADDR)
				j_func <= bus.wdata;
			if (bus.addr == J_DATA_ADDR)
				j_data <= bus.wdata[J_PINS-1:0];
			if (bus.addr == J_PULL_ADDR)
				j_pull <= bus.wdata;
		end
	end

	// ****************************************************************
	// read path
	// ****************************************************************
	// reserved and unmapped words answer zero, no bus error exists
	always_comb begin
		next_rdata = 32'h0000_0000;
		case (bus.addr)
			G_FUNC_ADDR: next_rdata = g_func;
			G_DATA_ADDR: next_rdata = {16'h0000, g_read};
			G_PULL_ADDR: next_rdata = {g_pull_hi, 16'h0000};
			H_FUNC_ADDR: next_rdata = {2'b00, h_func};
			H_DATA_ADDR: next_rdata = {17'h0_0000, h_read};
			H_PULL_ADDR: next_rdata = {2'b00, h_pull};
			J_FUNC_ADDR: next_rdata = j_func;
			J_DATA_ADDR: next_rdata = {16'h0000, j_read};
			J_PULL_ADDR: next_rdata = j_pull;
			default: next_rdata = 32'h0000_0000;
		endcase
	end

	// data is valid only in the cycle after the strobe, zero otherwise
	always_ff @(posedge ref_clk) begin
		if (!rst_n)
			rdata <= 32'h0000_0000;
		else
			rdata <= bus.rd ? next_rdata : 32'h0000_0000;
	end

	// ****************************************************************
	// peripheral outputs onto pins
	// ****************************************************************
	always_comb begin
		h_fn_o = '0;
		h_alt_o = '0;
		for (int c = 0; c < UART_CHANNELS; c++)
			h_fn_o[2*c] = uart_txd[c];
		h_fn_o[H_RTS0_PIN] = request_to_send_n[0];
		h_fn_o[H_RTS1_PIN] = request_to_send_n[1];
		h_fn_o[H_CLK_OUT0_PIN] = clock_output_zero;
		h_fn_o[H_CLK_OUT1_PIN] = clock_output_one;
		h_alt_o[H_RTS2_PIN] = request_to_send_n[2];
	end

	always_comb begin
		j_fn_o = '0;
		j_fn_o[J_CAMCLK_PIN] = camera_master_clock;
		j_fn_o[J_CAMRST_PIN] = camera_reset_line;
		j_fn_o[J_LED_PIN] = card0_activity_led;
	end

	// ****************************************************************
	// pin cells
	// ****************************************************************
	// port G functions live in another block, so its peripheral modes float
	ghj_port_cell #(.PINS(G_PINS)) u_port_g (
		.ref_clk(ref_clk),
		.rst_n(rst_n),
		.func(g_func),
		.data(g_data),
		.pull({g_pull_hi, G_LOW_PULL_OFF}),
		.pin_i(g_pin_i),
		.fn_o('0),
		.alt_o('0),
		.pin_o(g_pin_o),
		.pin_oe(g_pin_oe),
		.pull_up_en(g_pull_up_en),
		.pull_down_en(g_pull_down_en),
		.read_val(g_read)
	);

	ghj_port_cell #(
		.PINS(H_PINS),
		.FN_OUT_MASK(H_FN_OUT_MASK),
		.ALT_OK_MASK(H_ALT_OK_MASK),
		.ALT_OUT_MASK(H_ALT_OUT_MASK)
	) u_port_h (
		.ref_clk(ref_clk),
		.rst_n(rst_n),
		.func(h_func),
		.data(h_data),
		.pull(h_pull),
		.pin_i(h_pin_i),
		.fn_o(h_fn_o),
		.alt_o(h_alt_o),
		.pin_o(h_pin_o),
		.pin_oe(h_pin_oe),
		.pull_up_en(h_pull_up_en),
		.pull_down_en(h_pull_down_en),
		.read_val(h_read)
	);

	ghj_port_cell #(
		.PINS(J_PINS),
		.FN_OUT_MASK(J_FN_OUT_MASK)
	) u_port_j (
		.ref_clk(ref_clk),
		.rst_n(rst_n),
		.func(j_func),
		.data(j_data),
		.pull(j_pull),
		.pin_i(j_pin_i),
		.fn_o(j_fn_o),
		.alt_o('0),
		.pin_o(j_pin_o),
		.pin_oe(j_pin_oe),
		.pull_up_en(j_pull_up_en),
		.pull_down_en(j_pull_down_en),
		.read_val(j_read)
	);

	// ****************************************************************
	// pins into peripherals
	// ****************************************************************
	// deselected inputs park at idle: UART lines and active-low status high
	always_ff @(posedge ref_clk) begin
		if (!rst_n) begin
			uart_rxd <= '1;
			clear_to_send_n <= 3'h7;
			external_serial_clock <= 1'b0;
		end else begin
			for (int c = 0; c < UART_CHANNELS; c++)
				uart_rxd[c] <= (h_func[4*c+2 +: 2] == FN_PERIPH) ? h_pin_i[2*c+1] : 1'b1;
			clear_to_send_n[0] <= (h_func[2*H_CTS0_PIN +: 2] == FN_PERIPH) ? h_pin_i[H_CTS0_PIN] : 1'b1;
			clear_to_send_n[1] <= (h_func[2*H_CTS1_PIN +: 2] == FN_PERIPH) ? h_pin_i[H_CTS1_PIN] : 1'b1;
			clear_to_send_n[2] <= (h_func[2*H_CTS2_PIN +: 2] == FN_ALT) ? h_pin_i[H_CTS2_PIN] : 1'b1;
			external_serial_clock <= (h_func[2*H_EXTCLK_PIN +: 2] == FN_PERIPH) & h_pin_i[H_EXTCLK_PIN];
		end
	end

	// camera and card-slot inputs from port J
	always_ff @(posedge ref_clk) begin
		if (!rst_n) begin
			camera_pixel_bus <= '0;
			camera_pixel_clock <= 1'b0;
			camera_vertical_sync <= 1'b0;
			camera_line_reference <= 1'b0;
			card0_detect_n <= 1'b1;
			card0_write_protect_n <= 1'b1;
		end else begin
			for (int b = 0; b < CAM_BITS; b++)
				camera_pixel_bus[b] <= (j_func[2*b +: 2] == FN_PERIPH) & j_pin_i[b];
			camera_pixel_clock <= (j_func[2*J_PCLK_PIN +: 2] == FN_PERIPH) & j_pin_i[J_PCLK_PIN];
			camera_vertical_sync <= (j_func[2*J_VSYNC_PIN +: 2] == FN_PERIPH) & j_pin_i[J_VSYNC_PIN];
			camera_line_reference <= (j_func[2*J_HREF_PIN +: 2] == FN_PERIPH) & j_pin_i[J_HREF_PIN];
			card0_detect_n <= (j_func[2*J_CD_PIN +: 2] == FN_PERIPH) ? j_pin_i[J_CD_PIN] : 1'b1;
			card0_write_protect_n <= (j_func[2*J_WP_PIN +: 2] == FN_PERIPH) ? j_pin_i[J_WP_PIN] : 1'b1;
		end
	end

	// ****************************************************************
	// checks
	// ****************************************************************
	default clocking @(posedge ref_clk); endclocking
	default disable iff (!rst_n);

	sequence s_hdata_out_write;
		bus.wr && bus.addr == H_DATA_ADDR && h_func[1:0] == FN_OUTPUT;
	endsequence

	sequence s_no_write;
		!bus.wr;
	endsequence

	sequence s_hfunc_write;
		bus.wr && bus.addr == H_FUNC_ADDR;
	endsequence

	sequence s_jpull_write;
		bus.wr && bus.addr == J_PULL_ADDR;
	endsequence

	a_input_readback: assert property (
		bus.rd && bus.addr == H_DATA_ADDR && h_func[1:0] == FN_INPUT |=> rdata[0] == $past(h_pin_i[0]))
		else $error("input pin did not read back its level");

	a_output_drive: assert property (
		s_hdata_out_write ##1 s_no_write |=> h_pin_oe[0] && h_pin_o[0] == $past(bus.wdata[0], 2))
		else $error("output pin not driven from data register");

	a_pull_decode: assert property (
		1'b1 |=> h_pull_up_en[3] == ($past(h_pull[7:6]) == PULL_UP)
			&& h_pull_down_en[3] == ($past(h_pull[7:6]) == PULL_DOWN))
		else $error("pull selector decoded wrongly");

	a_g_pull_low: assert property (
		bus.rd && bus.addr == G_PULL_ADDR |=> rdata[15:0] == 16'h0000 && rdata[31:16] == $past(g_pull_hi))
		else $error("port G pull word layout wrong");

	a_input_float: assert property (
		h_func[9:8] == FN_INPUT |=> !h_pin_oe[4])
		else $error("input-mode pin is driven");

	a_alt_cts_two: assert property (
		h_func[15:14] == FN_ALT |=> clear_to_send_n[2] == $past(h_pin_i[7]))
		else $error("channel 2 clear-to-send not routed");

	a_uart_rx_route: assert property (
		h_func[3:2] == FN_PERIPH |=> uart_rxd[0] == $past(h_pin_i[1]))
		else $error("receive line 0 not routed");

	a_camera_clock: assert property (
		j_func[17:16] == FN_PERIPH |=> camera_pixel_clock == $past(j_pin_i[8]))
		else $error("camera pixel clock not routed");

	a_reset_values: assert property (
		$rose(rst_n) |-> h_func == '0 && j_func == FUNC_RST && g_func == FUNC_RST
			&& h_pull == H_PULL_RST[2*H_PINS-1:0] && j_pull == J_PULL_RST && g_pull_hi == G_PULL_RST)
		else $error("control register reset value wrong");

	a_hfunc_decode: assert property (
		s_hfunc_write ##1 (bus.rd && bus.addr == H_FUNC_ADDR) |=> rdata == {2'b00, $past(bus.wdata[29:0], 2)})
		else $error("port H selector readback wrong");

	a_jpull_timing: assert property (
		s_jpull_write ##1 s_no_write |=> j_pull_down_en[0] == ($past(bus.wdata[1:0], 2) == PULL_DOWN))
		else $error("port J pull write not applied on time");

	a_reserved_zero: assert property (
		bus.rd && (bus.addr == H_RSVD_ADDR || bus.addr == J_RSVD_ADDR) |=> rdata == 32'h0000_0000)
		else $error("reserved word did not read zero");

endmodule // ghj_gpio_ports

// ==== testbench/ghj_pin_model.sv ====
/*
 * Board model for one port: pads, pull resistors and far-side drivers.
 * Assumes the pulls are weak and an enabled external driver beats them.
 */
`timescale 1ns/1ns
module ghj_pin_model
	import ghj_pkg::*;
#(
	parameter int PINS = 16
) (
	input wire logic [PINS-1:0] pin_o,
	input wire logic [PINS-1:0] pin_oe,
	input wire logic [PINS-1:0] pull_up_en,
	input wire logic [PINS-1:0] pull_down_en,
	input wire logic [PINS-1:0] ext,
	input wire logic ext_en,
	output logic [PINS-1:0] pin_i
);
	// ********************************
	// pin resolution
	// ********************************
	// a released pin with no pull floats: show the inverse of ext so a
	// stale level never passes for a real one
	always_comb begin
		for (int k = 0; k < PINS; k++) begin
			if (pin_oe[k]) begin
				pin_i[k] = pin_o[k];
			end else if (ext_en) begin
				pin_i[k] = ext[k];
			end else if (pull_up_en[k]) begin
				pin_i[k] = 1'b1;
			end else if (pull_down_en[k]) begin
				pin_i[k] = 1'b0;
			end else begin
				pin_i[k] = ~ext[k];
			end
		end
	end
endmodule // ghj_pin_model

// ==== testbench/tb_ghj_gpio_ports.sv ====
/*
 * Self-checking bench for the port G/H/J pin controller: registers,
 * pin modes, pulls and peripheral routing.
 * Assumes pin models stand in for pads, board and external parts.
 */
`timescale 1ns/1ns
`define CHK(nm, e, g) begin n_checks++; if ((g) !== (e)) begin fail_count++; \
	$display("CHECK FAILED %s exp=%h got=%h", nm, e, g); end end
module tb_ghj_gpio_ports
	import ghj_pkg::*;
;
	logic ref_clk;
	logic rst_n;
	ghj_bus_s bus;
	logic [31:0] rdata;
	logic [G_PINS-1:0] g_i, g_o, g_oe, g_pu, g_pd, ext_g;
	logic [H_PINS-1:0] h_i, h_o, h_oe, h_pu, h_pd, ext_h;
	logic [J_PINS-1:0] j_i, j_o, j_oe, j_pu, j_pd, ext_j;
	logic ext_en;
	logic [3:0] txd, rxd;
	logic [2:0] rts_n, cts_n;
	logic uclk, clk0, clk1, mclk, crst, led, cd_n, wp_n, pclk, vsync, href;
	logic [7:0] cam;
	int fail_count;
	int n_checks;

	ghj_gpio_ports ghj_gpio_ports_inst (.ref_clk(ref_clk), .rst_n(rst_n), .bus(bus), .rdata(rdata),
		.g_pin_i(g_i), .g_pin_o(g_o), .g_pin_oe(g_oe), .g_pull_up_en(g_pu), .g_pull_down_en(g_pd),
		.h_pin_i(h_i), .h_pin_o(h_o), .h_pin_oe(h_oe), .h_pull_up_en(h_pu), .h_pull_down_en(h_pd),
		.j_pin_i(j_i), .j_pin_o(j_o), .j_pin_oe(j_oe), .j_pull_up_en(j_pu), .j_pull_down_en(j_pd),
		.uart_txd(txd), .uart_rxd(rxd), .request_to_send_n(rts_n), .clear_to_send_n(cts_n),
		.external_serial_clock(uclk), .clock_output_zero(clk0), .clock_output_one(clk1),
		.camera_pixel_bus(cam), .camera_pixel_clock(pclk), .camera_vertical_sync(vsync),
		.camera_line_reference(href), .camera_master_clock(mclk), .camera_reset_line(crst),
		.card0_activity_led(led), .card0_detect_n(cd_n), .card0_write_protect_n(wp_n));
	ghj_pin_model #(.PINS(G_PINS)) g_ghj_pin_model_inst (.pin_o(g_o), .pin_oe(g_oe), .pull_up_en(g_pu),
		.pull_down_en(g_pd), .ext(ext_g), .ext_en(ext_en), .pin_i(g_i));
	ghj_pin_model #(.PINS(H_PINS)) h_ghj_pin_model_inst (.pin_o(h_o), .pin_oe(h_oe), .pull_up_en(h_pu),
		.pull_down_en(h_pd), .ext(ext_h), .ext_en(ext_en), .pin_i(h_i));
	ghj_pin_model #(.PINS(J_PINS)) j_ghj_pin_model_inst (.pin_o(j_o), .pin_oe(j_oe), .pull_up_en(j_pu),
		.pull_down_en(j_pd), .ext(ext_j), .ext_en(ext_en), .pin_i(j_i));

	// ********************************
	// bus tasks and closing
	// ********************************
	task automatic wr(input logic [31:0] a, input logic [31:0] d);
		@(posedge ref_clk);
		bus <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
		@(posedge ref_clk);
		bus <= '0;
	endtask

	// read data stand only in the cycle after the strobe
	task automatic rd_chk(input logic [31:0] a, input logic [31:0] e, input string nm);
		@(posedge ref_clk);
		bus <= '{addr: a, wdata: 32'h0, wr: 1'b0, rd: 1'b1};
		@(posedge ref_clk);
		bus <= '0;
		#1;
		`CHK(nm, e, rdata)
	endtask

	// write then read one word with no idle cycle between the strobes
	task automatic wr_rd_chk(input logic [31:0] a, input logic [31:0] d, input logic [31:0] e, input string nm);
		@(posedge ref_clk);
		bus <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
		@(posedge ref_clk);
		bus <= '{addr: a, wdata: 32'h0, wr: 1'b0, rd: 1'b1};
		@(posedge ref_clk);
		bus <= '0;
		#1;
		`CHK(nm, e, rdata)
	endtask

	// pins follow one edge after the write, peripherals one more
	task automatic settle;
		repeat (3) @(posedge ref_clk);
		#1;
	endtask

	task automatic end_sim;
		if (fail_count == 0 && n_checks > 0) begin
			$display("*** PASS ***");
		end else begin
			$display("*** FAIL ***");
		end
		$finish;
	endtask

	initial begin
		ref_clk = 1'b0;
		forever #4 ref_clk = ~ref_clk;
	end

	// watchdog: a hang counts as a mismatch
	initial begin
		repeat (20000) @(posedge ref_clk);
		fail_count++;
		end_sim;
	end

	// ********************************
	// scenarios
	// ********************************
	initial begin
		fail_count = 0;
		n_checks = 0;
		rst_n = 1'b0;
		bus = '0;
		ext_en = 1'b0;
		ext_g = '0;
		ext_h = '0;
		ext_j = '0;
		txd = 4'hA;
		rts_n = 3'h1;
		clk0 = 1'b1;
		clk1 = 1'b0;
		mclk = 1'b1;
		crst = 1'b0;
		led = 1'b1;
		repeat (16) @(posedge ref_clk);
		rst_n <= 1'b1;
		settle;
		// reset values; pins float onto the pull-downs, except port J pins 15..14 (pull-up) and port G pins 7..0 (no pull)
		rd_chk(H_FUNC_ADDR, 32'h0, "h_func");
		rd_chk(J_FUNC_ADDR, 32'h0, "j_func");
		rd_chk(G_FUNC_ADDR, 32'h0, "g_func");
		rd_chk(H_PULL_ADDR, 32'h2AAAAAAA, "h_pull");
		rd_chk(J_PULL_ADDR, 32'h0AAAAAAA, "j_pull");
		rd_chk(G_PULL_ADDR, 32'hAAAA0000, "g_pull");
		rd_chk(H_DATA_ADDR, 32'h0, "h_data");
		`CHK("h_pd", 15'h7FFF, h_pd)
		`CHK("h_pu", 15'h0, h_pu)
		`CHK("j_pd", 16'h3FFF, j_pd)
		`CHK("j_pu", 16'hC000, j_pu)
		`CHK("g_pd", 16'hFF00, g_pd)
		`CHK("h_oe", 15'h0, h_oe)
		// every pull code, four pins per byte
		wr(H_PULL_ADDR, 32'hE4E4E4E4);
		wr(J_PULL_ADDR, 32'hE4E4E4E4);
		settle;
		rd_chk(H_PULL_ADDR, 32'h24E4E4E4, "h_pull");
		rd_chk(J_PULL_ADDR, 32'hE4E4E4E4, "j_pull");
		`CHK("h_pu", 15'h1111, h_pu)
		`CHK("h_pd", 15'h4444, h_pd)
		`CHK("j_pu", 16'h1111, j_pu)
		`CHK("j_pd", 16'h4444, j_pd)
		// upper half only on port G
		wr(G_PULL_ADDR, 32'h5555FFFF);
		ext_en <= 1'b1;
		ext_g <= 16'h1234;
		ext_h <= 15'h2A5C;
		ext_j <= 16'hC3A5;
		wr(H_PULL_ADDR, 32'h55555555);
		wr(J_PULL_ADDR, 32'h55555555);
		settle;
		rd_chk(G_PULL_ADDR, 32'h55550000, "g_pull");
		`CHK("g_pulls", 16'h0, g_pu | g_pd)
		// input mode reads the pin level
		rd_chk(H_DATA_ADDR, 32'h00002A5C, "h_data");
		rd_chk(J_DATA_ADDR, 32'h0000C3A5, "j_data");
		rd_chk(G_DATA_ADDR, 32'h00001234, "g_data");
		// output mode drives the data bits
		wr(H_FUNC_ADDR, 32'h15555555);
		wr(H_DATA_ADDR, 32'hFFFF5A3C);
		wr(J_FUNC_ADDR, 32'h55555555);
		wr(J_DATA_ADDR, 32'h0000F00F);
		wr(G_FUNC_ADDR, 32'h55555555);
		wr(G_DATA_ADDR, 32'h0000A5C3);
		settle;
		`CHK("h_oe", 15'h7FFF, h_oe)
		`CHK("h_o", 15'h5A3C, h_o)
		`CHK("j_oe", 16'hFFFF, j_oe)
		`CHK("j_o", 16'hF00F, j_o)
		`CHK("g_oe", 16'hFFFF, g_oe)
		`CHK("g_o", 16'hA5C3, g_o)
		rd_chk(H_DATA_ADDR, 32'h00005A3C, "h_data");
		rd_chk(J_DATA_ADDR, 32'h0000F00F, "j_data");
		// port H primary functions
		ext_h <= 15'h1482;
		wr_rd_chk(H_FUNC_ADDR, 32'h2AAAAAAA, 32'h2AAAAAAA, "h_func");
		settle;
		`CHK("h_oe", 15'h6A55, h_oe)
		`CHK("h_o", 15'h2244, h_o & 15'h6A55)
		`CHK("rxd", 4'h9, rxd)
		`CHK("cts_n", 3'h6, cts_n)
		`CHK("uclk", 1'b1, uclk)
		// second functions on pins 7 and 6, reserved on pin 0
		ext_h <= 15'h1402;
		wr(H_FUNC_ADDR, 32'h2AAAFAAB);
		settle;
		`CHK("h_oe", 15'h6A54, h_oe)
		`CHK("h_o", 15'h2204, h_o & 15'h6A54)
		`CHK("cts_n", 3'h2, cts_n)
		`CHK("rxd", 4'h9, rxd)
		// port J camera and card slot
		ext_j <= 16'h855A;
		wr(J_FUNC_ADDR, 32'hAAAAAAAA);
		settle;
		`CHK("j_oe", 16'h3800, j_oe)
		`CHK("j_o", 16'h2800, j_o & 16'h3800)
		`CHK("cam", 8'h5A, cam)
		`CHK("cam_sync", 3'h5, {pclk, vsync, href})
		`CHK("card_n", 2'h2, {wp_n, cd_n})
		// reserved and unmapped words
		wr(H_RSVD_ADDR, 32'hFFFFFFFF);
		wr(J_RSVD_ADDR, 32'hFFFFFFFF);
		rd_chk(H_RSVD_ADDR, 32'h0, "h_rsvd");
		rd_chk(J_RSVD_ADDR, 32'h0, "j_rsvd");
		rd_chk(32'h56000080, 32'h0, "unmapped");
		rd_chk(H_PULL_ADDR, 32'h15555555, "h_pull");
		end_sim;
	end
endmodule // tb_ghj_gpio_ports
